// ---- src/oc_defs.svh ----
`ifndef OC_DEFS_SVH
`define OC_DEFS_SVH

`define CNT_W 16
`define MODE_W 3
`define SYNC_W 5
`define TSEL_W 3
`define NUM_TB 8
`define SYNC_NONE 5'h00
`define TIMER_START 16'h0000

`endif

// ---- src/oc_pkg.sv ----
package oc_pkg;
    `include "oc_defs.svh"

    // every compare operation lives below the top bit; 1xx is reserved
    typedef enum logic [2:0] {
        CM_SINGLE_HIGH,
        CM_TOGGLE,
        CM_DUAL_SINGLE,
        CM_DUAL_CONT,
        CM_RSVD4,
        CM_RSVD5,
        CM_RSVD6,
        CM_RSVD7
    } cmode_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_RUN,
        ST_DONE
    } ostate_t;

    typedef struct packed {
        logic [`CNT_W-1:0] primary_compare_value;
        logic [`CNT_W-1:0] secondary_compare_value;
        logic [`MODE_W-1:0] compare_mode_select;
        logic trigger_enable_bit;
        logic trigger_mode_select;
        logic trigger_state_bit;
        logic [`SYNC_W-1:0] sync_source_select;
        logic [`TSEL_W-1:0] time_base_select;
    } oc_cfg_t;

    typedef struct packed {
        ostate_t st;
        logic pin;
        logic trig_stat;
        logic running;
        logic [`CNT_W-1:0] base_cnt;
        logic [`CNT_W-1:0] prev_cnt;
        logic prev_run;
    } oc_state_t;
endpackage

// ---- src/output_compare_timing.sv ----
`timescale 1ns/1ps
// Function
// - single-shot and continuous pulse modes offered
// - toggle mode inverts pin every match
// - pulse rises on primary, falls on secondary
// - compare values count from timer start zero
// - secondary value only used in dual modes
// - mode field top bit set is reserved
// - trigger enable selects trigger versus synchronous
// - trigger mode and state bits configure triggering
// - sync source zero means free running
// - time base select chooses compared timer
// - synchronous mode starts when timer runs
// - trigger mode idles until trigger event
module output_compare_timing
    import oc_pkg::*;
#(
    parameter int CNT_W = `CNT_W,
    parameter int NUM_TB = `NUM_TB,
    parameter int NUM_SRC = 32
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // configuration
    input oc_pkg::oc_cfg_t cfg,
    input wire logic sw_trigger,
    // timers, same clock domain
    input wire logic [NUM_TB*CNT_W-1:0] tb_count,
    input wire logic [NUM_TB-1:0] timer_run_bit,
    input wire logic [NUM_TB*CNT_W-1:0] timer_period_value,
    // trigger and sync sources
    input wire logic [NUM_SRC-1:0] src_event,
    // outputs
    output logic compare_output_pin,
    output logic trig_status,
    output logic active
);
    import oc_pkg::*;

    oc_state_t s_q, s_d;

    logic [CNT_W-1:0] cnt_sel;
    logic run_sel;
    logic [CNT_W-1:0] elapsed;
    logic src_hit;
    logic prim_hit;
    logic sec_hit;
    logic period_hit;
    logic dual;
    cmode_t mode;

    function automatic logic [CNT_W-1:0] pick(
        input logic [NUM_TB*CNT_W-1:0] bus,
        input logic [`TSEL_W-1:0] idx);
        pick = bus[idx*CNT_W +: CNT_W];
    endfunction

    always_comb
    begin
        mode = cmode_t'(cfg.compare_mode_select);
        cnt_sel = pick(tb_count, cfg.time_base_select);
        run_sel = timer_run_bit[cfg.time_base_select];
        // offset so the first counted value after start is zero
        elapsed = cnt_sel - s_q.base_cnt;
        // zero source means none: free running, never a trigger
        src_hit = (cfg.sync_source_select != `SYNC_NONE)
            && src_event[cfg.sync_source_select];
        dual = (mode == CM_DUAL_SINGLE) || (mode == CM_DUAL_CONT);
        prim_hit = s_q.running && run_sel
            && (elapsed == cfg.primary_compare_value);
        sec_hit = s_q.running && run_sel && dual
            && (elapsed == cfg.secondary_compare_value);
        period_hit = (elapsed == pick(timer_period_value,
            cfg.time_base_select));
    end

    always_comb
    begin
        s_d = s_q;
        s_d.prev_run = run_sel;
        s_d.prev_cnt = cnt_sel;
        // hardware source or sw_trigger pulse sets status; set wins over clear
        if (cfg.trigger_enable_bit && (src_hit || sw_trigger))
            s_d.trig_stat = 1'b1;
        else if (!cfg.trigger_state_bit && !cfg.trigger_mode_select)
            s_d.trig_stat = 1'b0;
        if (cfg.trigger_state_bit)
            s_d.trig_stat = 1'b1; // software trigger
        // reserved modes hold the channel idle with the pin low
        if (cfg.compare_mode_select[2])
        begin
            s_d.st = ST_IDLE;
            s_d.running = 1'b0;
            s_d.pin = 1'b0;
        end
        else
        begin
            case (s_q.st)
                ST_IDLE:
                begin
                    s_d.st = ST_ARMED;
                end
                ST_ARMED:
                begin
                    if (!cfg.trigger_enable_bit && run_sel)
                    begin
                        s_d.st = ST_RUN;
                        s_d.running = 1'b1;
                        s_d.base_cnt = s_q.prev_run ? cnt_sel
                            : `TIMER_START;
                    end
                    else if (cfg.trigger_enable_bit && run_sel
                        && s_d.trig_stat)
                    begin
                        s_d.st = ST_RUN;
                        s_d.running = 1'b1;
                        s_d.base_cnt = cnt_sel;
                    end
                end
                ST_RUN:
                begin
                    if (src_hit && !cfg.trigger_enable_bit)
                        s_d.base_cnt = cnt_sel; // resync
                    case (mode)
                        CM_SINGLE_HIGH:
                        begin
                            if (prim_hit)
                            begin
                                s_d.pin = 1'b1;
                                s_d.st = ST_DONE;
                            end
                        end
                        CM_TOGGLE:
                        begin
                            if (prim_hit)
                                s_d.pin = ~s_q.pin;
                        end
                        CM_DUAL_SINGLE, CM_DUAL_CONT:
                        begin
                            if (prim_hit)
                                s_d.pin = 1'b1;
                            if (sec_hit)
                            begin
                                s_d.pin = 1'b0;
                                if (mode == CM_DUAL_SINGLE)
                                    s_d.st = ST_DONE;
                            end
                        end
                        default:
                        begin
                            s_d.st = ST_IDLE;
                        end
                    endcase
                    // the timer itself wraps to zero after its period,
                    // so elapsed must follow it from zero again
                    if (period_hit && s_q.st == ST_RUN)
                        s_d.base_cnt = `TIMER_START;
                    // a stopped timer parks the channel until it runs
                    if (!run_sel)
                    begin
                        s_d.st = ST_ARMED;
                        s_d.running = 1'b0;
                    end
                end
                ST_DONE:
                begin
                    s_d.running = 1'b0;
                end
                default:
                begin
                    s_d.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            compare_output_pin <= 1'b0;
            trig_status <= 1'b0;
            active <= 1'b0;
        end
        else
        begin
            compare_output_pin <= s_d.pin;
            trig_status <= s_d.trig_stat;
            active <= s_d.running;
        end
    end

    a_toggle_flip: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mode == CM_TOGGLE && prim_hit && s_q.st == ST_RUN
        && !cfg.compare_mode_select[2])
        |=> compare_output_pin != $past(compare_output_pin))
        else $error("toggle did not invert pin");

    a_rise_primary: assert property (@(posedge ref_clk) disable iff (!nrst)
        (dual && prim_hit && !sec_hit && s_q.st == ST_RUN)
        |=> compare_output_pin)
        else $error("pin did not rise on primary match");

    a_fall_second: assert property (@(posedge ref_clk) disable iff (!nrst)
        (dual && sec_hit && s_q.st == ST_RUN) |=> !compare_output_pin)
        else $error("pin did not fall on secondary match");

    a_reserved_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
        cfg.compare_mode_select[2] |=> !compare_output_pin && !active)
        else $error("reserved mode left pin active");

    a_trig_wait: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_q.st == ST_ARMED && cfg.trigger_enable_bit && !s_d.trig_stat)
        |=> !active)
        else $error("started without trigger");

    a_sync_start: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_q.st == ST_ARMED && !cfg.trigger_enable_bit && run_sel
        && !cfg.compare_mode_select[2])
        |=> active)
        else $error("sync mode did not start");

    a_dual_single_stop: assert property (@(posedge ref_clk)
        disable iff (!nrst)
        (mode == CM_DUAL_SINGLE && sec_hit && s_q.st == ST_RUN)
        |=> ##1 !active)
        else $error("dual single shot kept running");

    a_dual_cont_run: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mode == CM_DUAL_CONT && sec_hit && s_q.st == ST_RUN)
        |=> active)
        else $error("continuous pulse stopped after one pulse");

    // single compare must ignore the secondary value entirely
    a_single_primary: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mode == CM_SINGLE_HIGH && s_q.st == ST_RUN && !prim_hit)
        |=> compare_output_pin == $past(compare_output_pin))
        else $error("single mode pin moved without primary match");

    a_toggle_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mode == CM_TOGGLE && s_q.st == ST_RUN && !prim_hit)
        |=> $stable(compare_output_pin))
        else $error("toggle pin moved without match");

    a_period_restart: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_q.st == ST_RUN && period_hit && !cfg.compare_mode_select[2])
        |=> s_q.base_cnt == `TIMER_START)
        else $error("elapsed count not restarted at period");

    a_sw_trig_stat: assert property (@(posedge ref_clk) disable iff (!nrst)
        cfg.trigger_state_bit |=> trig_status)
        else $error("software trigger did not set status");

    a_hw_trig_stat: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cfg.trigger_enable_bit && src_hit) |=> trig_status)
        else $error("hardware trigger did not set status");

    // the channel must not count while its time base is stopped
    a_idle_no_timer: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_q.st == ST_ARMED && !run_sel) |=> !active)
        else $error("channel active with timer stopped");

    a_done_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_q.st == ST_DONE && !cfg.compare_mode_select[2])
        |=> $stable(compare_output_pin))
        else $error("pin moved after single shot finished");

    a_single_done: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mode == CM_SINGLE_HIGH && prim_hit && s_q.st == ST_RUN)
        |=> compare_output_pin ##1 !active)
        else $error("single shot did not finish");

    a_no_src_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cfg.sync_source_select == `SYNC_NONE) |-> !src_hit)
        else $error("zero source produced event");
endmodule

// ---- verification/tb_output_compare_timing.sv ----
`timescale 1ns/1ps
module tb_output_compare_timing;
    import oc_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic sw_trigger = 1'b0;
    oc_cfg_t cfg = '0;
    logic [127:0] tb_count = '0;
    logic [7:0] timer_run_bit = '0;
    logic [127:0] timer_period_value = '0;
    logic [31:0] src_event = '0;
    logic compare_output_pin;
    logic trig_status;
    logic active;
    int n_errors = 0;
    int total_checks = 0;
    int cnt;
    int prd;
    int ts;
    logic exp_pin;
    logic shot_done;

    output_compare_timing dut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .cfg(cfg),
        .sw_trigger(sw_trigger),
        .tb_count(tb_count),
        .timer_run_bit(timer_run_bit),
        .timer_period_value(timer_period_value),
        .src_event(src_event),
        .compare_output_pin(compare_output_pin),
        .trig_status(trig_status),
        .active(active)
    );

    always #10 ref_clk = ~ref_clk;

    task automatic chk(input string what, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("FAIL %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // other timers carry random counts so a wrong select shows up
    task automatic restart(input logic [2:0] mode, input int tsel);
        @(posedge ref_clk);
        #1;
        nrst = 1'b0;
        timer_run_bit = '0;
        cnt = 0;
        exp_pin = 1'b0;
        shot_done = 1'b0;
        ts = tsel;
        cfg.compare_mode_select = mode;
        cfg.time_base_select = tsel[2:0];
        cfg.primary_compare_value = 16'(3 + $urandom % 14);
        cfg.secondary_compare_value = cfg.primary_compare_value + 16'(1 + $urandom % 8);
        prd = int'(cfg.secondary_compare_value) + $urandom % 4;
        tb_count = {$urandom, $urandom, $urandom, $urandom};
        tb_count[ts*16 +: 16] = 16'h0000;
        timer_period_value = {$urandom, $urandom, $urandom, $urandom};
        timer_period_value[ts*16 +: 16] = prd[15:0];
        repeat (5) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // reference timer and pin model, evaluated on what the edge sampled
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            if (cnt == int'(cfg.primary_compare_value) && !shot_done)
                exp_pin = (cfg.compare_mode_select == CM_TOGGLE) ? ~exp_pin : 1'b1;
            if ((cfg.compare_mode_select == CM_DUAL_SINGLE
                || cfg.compare_mode_select == CM_DUAL_CONT)
                && cnt == int'(cfg.secondary_compare_value) && !shot_done)
            begin
                exp_pin = 1'b0;
                shot_done = (cfg.compare_mode_select == CM_DUAL_SINGLE);
            end
            #1;
            chk("pin", exp_pin, compare_output_pin);
            cnt = (cnt == prd) ? 0 : cnt + 1;
            tb_count[ts*16 +: 16] = cnt[15:0];
        end
    endtask

    task automatic wait_active();
        int i;
        for (i = 0; i < 8 && active !== 1'b1; i++)
            @(posedge ref_clk);
        #1;
        chk("active", 1'b1, active);
        if (active !== 1'b1)
            end_sim();
    endtask

    initial
    begin
        cnt = $urandom(32'h9143);
        for (int m = 0; m < 8; m++)
        begin
            restart(m[2:0], m);
            chk("active", 1'b0, active);
            timer_run_bit[ts] = 1'b1;
            tick(2);
            chk("active", (m <= 3), active);
        end
        repeat (3)
        begin
            restart(CM_TOGGLE, $urandom % 8);
            timer_run_bit[ts] = 1'b1;
            tick(3 * prd + 5);
            restart(CM_SINGLE_HIGH, $urandom % 8);
            timer_run_bit[ts] = 1'b1;
            tick(2 * prd + 5);
            restart(CM_DUAL_CONT, $urandom % 8);
            timer_run_bit[ts] = 1'b1;
            tick(3 * prd + 5);
            restart(CM_DUAL_SINGLE, $urandom % 8);
            timer_run_bit[ts] = 1'b1;
            tick(3 * prd + 5);
        end
        // trigger mode must hold off until the selected source fires
        cfg.trigger_enable_bit = 1'b1;
        cfg.sync_source_select = 5'h05;
        restart(CM_TOGGLE, 2);
        timer_run_bit[ts] = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("active", 1'b0, active);
        src_event[4] = 1'b1;
        @(posedge ref_clk);
        #1;
        src_event[4] = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("active", 1'b0, active);
        src_event[5] = 1'b1;
        @(posedge ref_clk);
        #1;
        src_event[5] = 1'b0;
        wait_active();
        // software trigger through the state bit
        restart(CM_TOGGLE, 4);
        timer_run_bit[ts] = 1'b1;
        cfg.trigger_state_bit = 1'b1;
        wait_active();
        chk("trig_status", 1'b1, trig_status);
        // software pulse trigger on sw_trigger with the state bit clear
        cfg.trigger_state_bit = 1'b0;
        restart(CM_TOGGLE, 6);
        timer_run_bit[ts] = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("active", 1'b0, active);
        sw_trigger = 1'b1;
        @(posedge ref_clk);
        #1;
        sw_trigger = 1'b0;
        wait_active();
        end_sim();
    end
endmodule
